/* File: mac_pkg.sv */
// Package with register map, field positions and timing constants of the monitor converter control.
package mac_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0]  OPTION_ADDR_LO   = 8'h3A;
	localparam logic [7:0]  OPTION_ADDR_HI   = 8'h3B;
	localparam logic [15:0] OPTION_RESET     = 16'h2000;
	localparam logic [7:0]  RES_ADDR_FIRST   = 8'h26;
	localparam logic [7:0]  RES_ADDR_LAST    = 8'h2D;
	localparam int          BIT_REPEAT       = 15;
	localparam int          BIT_START        = 14;
	localparam int          BIT_RANGE        = 13;
	localparam int          NUM_CH           = 8;
	localparam logic [2:0]  CH_FIRST         = 3'h0;
	localparam logic [2:0]  CH_LAST          = 3'h7;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_MHZ          = 100;
	localparam int          PASS_TIME_MS     = 10;
	localparam int          REPEAT_TIME_MS   = 1000;
	localparam int          PASS_CYCLES      = PASS_TIME_MS * 1000 * CLK_MHZ;
	localparam int          REPEAT_CYCLES    = REPEAT_TIME_MS * 1000 * CLK_MHZ;
	localparam int          CH_CYCLES        = PASS_CYCLES / NUM_CH;
	typedef enum logic [1:0] {
		MAC_IDLE,
		MAC_CONV,
		MAC_WAIT
	} mac_state_t;
endpackage

/* File: mac_scan.sv */
// Scan control of the monitor converter with its option register and result registers.
`timescale 1ns/1ps
// What this block does
// - Scan battery, system, currents, power, bus, comparator
// - No conversions in low power mode
// - Enabling converter on battery leaves low power
// - Mode 0: one pass after start
// - Mode 1: repeat pass every second
// - Pass takes about ten milliseconds with all eight channels enabled, a disabled channel is skipped in one cycle
// - Start bit self-clears after one-shot pass
// - Results land in registers 0x26 to 0x2D
// - Range select 0 low, 1 high, default 1
// - Eight channel enables, all off by default
module mac_scan #(
	parameter int PASS_CYC   = mac_pkg::PASS_CYCLES,
	parameter int REPEAT_CYC = mac_pkg::REPEAT_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        low_power_req,
	input  wire logic        on_battery,
	input  wire logic [7:0]  conv_sample,
	output logic      [2:0]  conv_channel,
	output logic             conv_active,
	output logic             input_range_select,
	output logic             low_power_exit,
	output logic             scan_busy
);
	typedef struct packed {
		logic [15:0]         opt;
		logic [7:0][7:0]     res;
		mac_pkg::mac_state_t st;
		logic [2:0]          ch;
		logic [31:0]         tmr;
		logic [31:0]         rpt;
		logic                run;
		logic [7:0]          rdata;
		logic                lpx;
	} mac_st_t;

	logic    rst_meta_ff;
	logic    rst_sync_ff;
	mac_st_t cur_ff;
	mac_st_t nxt_cur;
	logic    lp_block;
	logic    ch_on;
	logic    start_req;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_cur   = cur_ff;
		ch_on     = cur_ff.opt[cur_ff.ch];
		start_req = cur_ff.opt[mac_pkg::BIT_START];
		lp_block  = low_power_req && !(on_battery && start_req);
		nxt_cur.lpx = on_battery && start_req;
		// Register writes.
		if (reg_wr && reg_addr == mac_pkg::OPTION_ADDR_LO) begin
			nxt_cur.opt[7:0] = reg_wdata;
		end
		if (reg_wr && reg_addr == mac_pkg::OPTION_ADDR_HI) begin
			nxt_cur.opt[15:8] = reg_wdata;
		end
		// Register reads.
		nxt_cur.rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == mac_pkg::OPTION_ADDR_LO) begin
				nxt_cur.rdata = cur_ff.opt[7:0];
			end else if (reg_addr == mac_pkg::OPTION_ADDR_HI) begin
				nxt_cur.rdata = cur_ff.opt[15:8];
			end else if (reg_addr >= mac_pkg::RES_ADDR_FIRST && reg_addr <= mac_pkg::RES_ADDR_LAST) begin
				nxt_cur.rdata = cur_ff.res[3'(reg_addr - mac_pkg::RES_ADDR_FIRST)];
			end
		end
		// Repeat interval counter.
		if (cur_ff.rpt != 32'h0) begin
			nxt_cur.rpt = cur_ff.rpt - 32'h1;
		end
		case (cur_ff.st)
			mac_pkg::MAC_IDLE: begin
				if (start_req && !lp_block) begin
					nxt_cur.st  = mac_pkg::MAC_CONV;
					nxt_cur.ch  = mac_pkg::CH_FIRST;
					nxt_cur.tmr = 32'(PASS_CYC / mac_pkg::NUM_CH);
					nxt_cur.rpt = 32'(REPEAT_CYC);
					nxt_cur.run = 1'b1;
				end
			end
			mac_pkg::MAC_CONV: begin
				if (lp_block) begin
					nxt_cur.st  = mac_pkg::MAC_IDLE;
					nxt_cur.run = 1'b0;
				end else if (!ch_on || cur_ff.tmr <= 32'h1) begin
					if (ch_on) begin
						nxt_cur.res[cur_ff.ch] = conv_sample;
					end
					nxt_cur.tmr = 32'(PASS_CYC / mac_pkg::NUM_CH);
					if (cur_ff.ch == mac_pkg::CH_LAST) begin
						nxt_cur.run = 1'b0;
						if (cur_ff.opt[mac_pkg::BIT_REPEAT]) begin
							nxt_cur.st = mac_pkg::MAC_WAIT;
						end else begin
							nxt_cur.st = mac_pkg::MAC_IDLE;
							if (!(reg_wr && reg_addr == mac_pkg::OPTION_ADDR_HI)) begin
								nxt_cur.opt[mac_pkg::BIT_START] = 1'b0;
							end
						end
					end else begin
						nxt_cur.ch = cur_ff.ch + 3'h1;
					end
				end else begin
					nxt_cur.tmr = cur_ff.tmr - 32'h1;
				end
			end
			mac_pkg::MAC_WAIT: begin
				if (!start_req || !cur_ff.opt[mac_pkg::BIT_REPEAT] || lp_block) begin
					nxt_cur.st = mac_pkg::MAC_IDLE;
				end else if (cur_ff.rpt <= 32'h1) begin
					nxt_cur.st  = mac_pkg::MAC_CONV;
					nxt_cur.ch  = mac_pkg::CH_FIRST;
					nxt_cur.rpt = 32'(REPEAT_CYC);
					nxt_cur.run = 1'b1;
				end
			end
			default: begin
				nxt_cur.st = mac_pkg::MAC_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			cur_ff     <= '0;
			cur_ff.opt <= mac_pkg::OPTION_RESET;
			cur_ff.st  <= mac_pkg::MAC_IDLE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			conv_channel       <= mac_pkg::CH_FIRST;
			conv_active        <= 1'b0;
			input_range_select <= 1'b1;
			low_power_exit     <= 1'b0;
			scan_busy          <= 1'b0;
		end else begin
			conv_channel       <= nxt_cur.ch;
			conv_active        <= nxt_cur.st == mac_pkg::MAC_CONV;
			input_range_select <= nxt_cur.opt[mac_pkg::BIT_RANGE];
			low_power_exit     <= nxt_cur.lpx;
			scan_busy          <= nxt_cur.run;
		end
	end

	assign reg_rdata = cur_ff.rdata;
endmodule // mac_scan

/* File: mac_conv_model.sv */
// Converter model that answers each channel with a known code.
`timescale 1ns/1ps
module mac_conv_model (
	input  wire logic [2:0] conv_channel,
	input  wire logic       conv_active,
	output logic      [7:0] conv_sample
);
	assign conv_sample = conv_active ? {5'h15, conv_channel} : {5'h0A, ~conv_channel};
endmodule // mac_conv_model

/* File: mac_scan_assertions.sv */
// Checker for the monitor converter scan control.
`timescale 1ns/1ps
module mac_scan_assertions #(
	parameter int PASS_CYC = 80
) (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       low_power_req,
	input wire logic       on_battery,
	input wire logic [2:0] conv_channel,
	input wire logic       conv_active,
	input wire logic       input_range_select,
	input wire logic       low_power_exit,
	input wire logic       scan_busy
);
	int n_ff;
	always_ff @(posedge clk or negedge rst_b) n_ff <= !rst_b ? 0 : (scan_busy ? n_ff + 1 : 0);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chan_order_a: assert property (conv_active && $past(conv_active) && conv_channel != $past(conv_channel)
		|-> conv_channel == $past(conv_channel) + 3'h1) else $error("channel order broken");
	no_lp_conv_a: assert property ($rose(conv_active) |-> !low_power_req || on_battery)
		else $error("conversion in low power");
	lp_exit_a: assert property (low_power_exit |-> $past(on_battery)) else $error("exit without battery");
	pass_len_a: assert property (n_ff <= PASS_CYC + 16) else $error("pass too long");
	busy_cover_a: assert property (conv_active |-> scan_busy) else $error("active while not busy");
	range_wr_a: assert property (reg_wr && reg_addr == 8'h3B |=> input_range_select == $past(reg_wdata[5]))
		else $error("range select not updated");
	idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data without read");
	unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00) else $error("unmapped read");
	cover property ($fell(scan_busy));
	cover property ($rose(low_power_exit));
	cover property (conv_active && conv_channel == 3'h7);
endmodule // mac_scan_assertions

/* File: mac_scan_tb.sv */
// Testbench for the monitor converter scan control.
`timescale 1ns/1ps
module mac_scan_tb;
	logic       clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, low_power_req = 1'b0, on_battery = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, conv_sample;
	logic [2:0] conv_channel;
	logic       conv_active, input_range_select, low_power_exit, scan_busy;
	int         n_fail = 0, checks = 0;
	mac_scan #(.PASS_CYC(80), .REPEAT_CYC(400)) dut_u (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .low_power_req, .on_battery, .conv_sample, .conv_channel, .conv_active, .input_range_select,
		.low_power_exit, .scan_busy);
	mac_conv_model model_u (.conv_channel, .conv_active, .conv_sample);
	task automatic finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk) reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge clk) reg_rd = 1'b0;
		cmp(reg_rdata, exp);
	endtask
	task automatic wait_busy(input logic lvl);
		for (int i = 0; i < 1000 && scan_busy !== lvl; i++) @(negedge clk);
		checks++;
		if (scan_busy !== lvl) begin
			n_fail++;
			$display("ERROR %0t busy wait timed out", $time);
			finish_test();
		end
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		rd(8'h3A, 8'h00);
		rd(8'h3B, 8'h20);
		rd(8'h00, 8'h00);
		wr(8'h3A, 8'h05);
		wr(8'h3B, 8'h60);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rd(8'h3B, 8'h20);
		rd(8'h26, 8'hA8);
		rd(8'h28, 8'hAA);
		rd(8'h27, 8'h00);
		low_power_req = 1'b1;
		wr(8'h3B, 8'h60);
		repeat (20) @(negedge clk);
		cmp({7'h00, scan_busy}, 8'h00);
		on_battery = 1'b1;
		wr(8'h3B, 8'h60);
		wait_busy(1'b1);
		cmp({7'h00, low_power_exit}, 8'h01);
		wait_busy(1'b0);
		low_power_req = 1'b0;
		wr(8'h3A, 8'hFF);
		wr(8'h3B, 8'hE0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rd(8'h2D, 8'hAF);
		rd(8'h3B, 8'hE0);
		wr(8'h3B, 8'h00);
		cmp({7'h00, input_range_select}, 8'h00);
		finish_test();
	end
endmodule // mac_scan_tb
bind mac_scan mac_scan_assertions #(.PASS_CYC(PASS_CYC)) chk_u (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata, .low_power_req, .on_battery, .conv_channel, .conv_active, .input_range_select,
	.low_power_exit, .scan_busy);
